// ==== rtl/wsf_pkg.sv ====
// Purpose: constants shared by the wheel speed frame encoder
// Assumes: 250 MHz core clock, current levels coded on two bits
// Notes: timing counts derive from times in their own units
//
// Notes on behaviour
// - Data bit 1 flags gap measurement invalid; 1 after power on.
// - Data bit 3 is direction validity, 1 valid, 0 invalid.
// - Data bits 5..7 carry gap value 0..7, bit 5 least significant.
// - Data bit 8 makes total frame parity even.
// - Below normal speed limit every frame sends all nine data bits.
// - Frame: half bit low, one bit pulse, half bit low, data bits.
// - A due speed pulse shortens the frame by dropping trailing data bits.
// - Bits sent fall with frequency, nine down to none; follows from timing.
// - A data bit once begun is always finished in full.
// - Dropped data bits are replaced by the low current level.
// - No increment within standstill timeout starts standstill frames.
// - Standstill frames repeat every 150 ms nominal.
// - Standstill frame speed pulse uses middle level, not high.
// - Several standstill frames may pass between two slow speed pulses.
// - New increment ends running standstill frame; speed pulse has priority.
// - Cut only between data bits; at least half bit low before pulse.
// - Standstill frames send direction 0 and direction validity 0.
// - Five standstill frames reset direction; valid again at third pulse.
// - Standstill sends invalid measurement and gap 0; five frames reset both; code resets only the invalid flag, gap value passes through.
// - After reset measurement stays invalid until two field extremes found.
// - Alarm sent 0 in standstill frames, reset to 0 after five.
// - After reset alarm stays 0 until two new extremes found.
// - Data bits Manchester coded low/middle, edge at bit midpoint.
package wsf_pkg;
  // ----------------------------------------
  // Line current levels
  // ----------------------------------------
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  // ----------------------------------------
  // Data bit positions
  // ----------------------------------------
  localparam int BIT_ALARM = 0;
  localparam int BIT_MEAS_INVALID = 1;
  localparam int BIT_UNUSED = 2;
  localparam int BIT_DIR_VALID = 3;
  localparam int BIT_DIR = 4;
  localparam int BIT_GAP_LSB = 5;
  localparam int BIT_GAP_MSB = 7;
  localparam int BIT_PARITY = 8;
  localparam logic [3:0] LAST_BIT = 4'h8;

  // ----------------------------------------
  // Standstill bookkeeping
  // ----------------------------------------
  localparam logic [2:0] SS_RESET_FRAMES = 3'h5;
  localparam logic [1:0] EXTREMES_NEEDED = 2'h2;
  localparam logic [1:0] PULSES_FOR_DIR = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BIT_PERIOD_NS = 50000;
  localparam int SS_PERIOD_MS = 150;
  localparam int TSTOP_MS = 150;
  localparam int HALF_BIT_CYCLES = BIT_PERIOD_NS * CLK_MHZ / 2000;
  localparam int SS_PERIOD_CYCLES = SS_PERIOD_MS * CLK_MHZ * 1000;
  localparam int TSTOP_CYCLES = TSTOP_MS * CLK_MHZ * 1000;
endpackage

// ==== rtl/frame_timing_if.sv ====
// Purpose: timing handshake between framer and its timers
// Assumes: single clock domain
// Notes: pulses are one cycle wide
interface frame_timing_if;
  logic restart;
  logic half_tick;
  logic motion_seen;
  logic standstill_due;

  modport framer (output restart, output motion_seen, input half_tick,
                  input standstill_due);
  modport bit_timer (input restart, output half_tick);
  modport ss_timer (input motion_seen, output standstill_due);
endinterface

// ==== rtl/half_bit_timer.sv ====
// Purpose: half bit period tick for the frame sequencer
// Assumes: restart aligns the first tick one half bit later
// Notes: free running between restarts
module half_bit_timer #(
  parameter int HALF_CYCLES = wsf_pkg::HALF_BIT_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  frame_timing_if.bit_timer tif
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (tif.restart || st_r.cnt == 32'(HALF_CYCLES - 1))
    begin
      st_nxt.cnt = 32'h0;
      st_nxt.tick = !tif.restart;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tif.half_tick = st_r.tick;
endmodule

// ==== rtl/standstill_timer.sv ====
// Purpose: standstill timeout and repeat period
// Assumes: motion_seen pulses on every speed increment
// Notes: first due after the timeout, then once per repeat period
module standstill_timer #(
  parameter int TSTOP = wsf_pkg::TSTOP_CYCLES,
  parameter int PERIOD = wsf_pkg::SS_PERIOD_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  frame_timing_if.ss_timer tif
);
  typedef struct packed {
    logic [31:0] cnt;
    logic first;
    logic due;
  } state_type;

  state_type st_r;
  state_type st_nxt;
  logic [31:0] limit;

  always_comb
  begin
    limit = st_r.first ? 32'(TSTOP - 1) : 32'(PERIOD - 1);
    st_nxt = st_r;
    st_nxt.due = 1'b0;
    if (tif.motion_seen)
    begin
      st_nxt.cnt = 32'h0;
      st_nxt.first = 1'b1;
    end
    else if (st_r.cnt >= limit)
    begin
      st_nxt.cnt = 32'h0;
      st_nxt.first = 1'b0;
      st_nxt.due = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      st_r <= '{cnt: 32'h0, first: 1'b1, due: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign tif.standstill_due = st_r.due;
endmodule

// ==== rtl/wheel_speed_frame_encoder.sv ====
// Purpose: builds and sends speed and standstill frames on the current line
// Assumes: signal path inputs come from logic on the same clock
// Notes: frame shortening falls out of timing; no frequency is measured
module wheel_speed_frame_encoder #(
  parameter int HALF_BIT_CYCLES = wsf_pkg::HALF_BIT_CYCLES,
  parameter int TSTOP_CYCLES = wsf_pkg::TSTOP_CYCLES,
  parameter int SS_PERIOD_CYCLES = wsf_pkg::SS_PERIOD_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic speed_increment,
  input wire logic rotation_dir_in,
  input wire logic direction_valid_in,
  input wire logic [2:0] gap_value_in,
  input wire logic gap_invalid_in,
  input wire logic air_gap_alarm_in,
  input wire logic extreme_found,
  output logic [1:0] current_level,
  output logic frame_busy,
  output logic standstill_frame,
  output logic direction_reset
);
  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_START = 5'h02,
    PH_PULSE = 5'h04,
    PH_GAP = 5'h08,
    PH_DATA = 5'h10
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic second_half;
    logic [3:0] bit_idx;
    logic [8:0] word;
    logic ss_frame;
    logic speed_pending;
    logic ss_pending;
    logic [2:0] ss_run;
    logic [1:0] extremes;
    logic [1:0] pulses_after;
    logic after_reset;
    logic [1:0] level;
    logic dir_reset;
    logic busy;
    logic ss_out;
  } state_type;

  state_type st_r;
  state_type st_nxt;
  frame_timing_if tif ();

  logic [8:0] speed_word;
  logic [8:0] standstill_word;
  logic [7:0] speed_body;
  logic meas_hold;
  logic dir_hold;
  logic [1:0] pulses_next;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  half_bit_timer #(
    .HALF_CYCLES(HALF_BIT_CYCLES)
  ) u_half_bit_timer (
    .clock(clock),
    .nrst(nrst),
    .tif(tif.bit_timer)
  );

  standstill_timer #(
    .TSTOP(TSTOP_CYCLES),
    .PERIOD(SS_PERIOD_CYCLES)
  ) u_standstill_timer (
    .clock(clock),
    .nrst(nrst),
    .tif(tif.ss_timer)
  );

  assign tif.motion_seen = speed_increment;

  // ----------------------------------------
  // Frame contents
  // ----------------------------------------
  // Counters saturate so the gates hold until the next standstill reset
  assign pulses_next = (st_r.pulses_after == wsf_pkg::PULSES_FOR_DIR) ?
                       st_r.pulses_after : st_r.pulses_after + 2'h1;
  assign meas_hold = st_r.after_reset && (st_r.extremes < wsf_pkg::EXTREMES_NEEDED);
  assign dir_hold = st_r.after_reset && (pulses_next < wsf_pkg::PULSES_FOR_DIR);

  always_comb
  begin
    speed_body = 8'h0;
    // Alarm and validity wait for two extremes after a reset
    speed_body[wsf_pkg::BIT_ALARM] = air_gap_alarm_in && !meas_hold;
    speed_body[wsf_pkg::BIT_MEAS_INVALID] = gap_invalid_in || meas_hold;
    speed_body[wsf_pkg::BIT_UNUSED] = 1'b0;
    speed_body[wsf_pkg::BIT_DIR_VALID] = direction_valid_in && !dir_hold;
    speed_body[wsf_pkg::BIT_DIR] = rotation_dir_in && !dir_hold;
    speed_body[wsf_pkg::BIT_GAP_MSB:wsf_pkg::BIT_GAP_LSB] = gap_value_in;
    speed_word = {^speed_body, speed_body};
  end

  always_comb
  begin
    standstill_word = 9'h0;
    standstill_word[wsf_pkg::BIT_MEAS_INVALID] = 1'b1;
    standstill_word[wsf_pkg::BIT_PARITY] = 1'b1;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.dir_reset = 1'b0;
    tif.restart = 1'b0;

    if (speed_increment)
      st_nxt.speed_pending = 1'b1;
    if (tif.standstill_due)
      st_nxt.ss_pending = 1'b1;
    if (extreme_found && st_r.extremes != wsf_pkg::EXTREMES_NEEDED)
      st_nxt.extremes = st_r.extremes + 2'h1;

    case (st_r.phase)
      PH_IDLE:
      begin
        st_nxt.level = wsf_pkg::LEVEL_LOW;
        if (st_r.speed_pending || st_r.ss_pending)
        begin
          tif.restart = 1'b1;
          st_nxt.phase = PH_START;
          // Flag must not carry over from the last frame into this start
          st_nxt.ss_frame = !st_r.speed_pending;
        end
      end
      PH_START:
      begin
        if (tif.half_tick)
        begin
          st_nxt.phase = PH_PULSE;
          st_nxt.second_half = 1'b0;
          st_nxt.ss_frame = !st_r.speed_pending;
          st_nxt.bit_idx = 4'h0;
          if (st_r.speed_pending)
          begin
            // Speed wins over a standstill frame waiting at the same time
            st_nxt.speed_pending = speed_increment;
            st_nxt.ss_pending = tif.standstill_due;
            st_nxt.word = speed_word;
            st_nxt.level = wsf_pkg::LEVEL_HIGH;
            st_nxt.ss_run = 3'h0;
            st_nxt.pulses_after = pulses_next;
            if (!meas_hold && !dir_hold)
              st_nxt.after_reset = 1'b0;
          end
          else
          begin
            st_nxt.ss_pending = tif.standstill_due;
            st_nxt.word = standstill_word;
            st_nxt.level = wsf_pkg::LEVEL_MID;
            if (st_r.ss_run != wsf_pkg::SS_RESET_FRAMES)
              st_nxt.ss_run = st_r.ss_run + 3'h1;
            if (st_r.ss_run == wsf_pkg::SS_RESET_FRAMES - 3'h1)
            begin
              // Fifth standstill frame in a row resets the signal path state
              st_nxt.dir_reset = 1'b1;
              st_nxt.after_reset = 1'b1;
              st_nxt.extremes = 2'h0;
              st_nxt.pulses_after = 2'h0;
            end
          end
        end
      end
      PH_PULSE:
      begin
        if (tif.half_tick)
        begin
          st_nxt.second_half = !st_r.second_half;
          if (st_r.second_half)
          begin
            st_nxt.phase = PH_GAP;
            st_nxt.level = wsf_pkg::LEVEL_LOW;
          end
        end
      end
      PH_GAP:
      begin
        if (tif.half_tick)
        begin
          if (st_r.speed_pending)
          begin
            // Gap already gave half a bit low; start adds another
            st_nxt.phase = PH_START;
            st_nxt.level = wsf_pkg::LEVEL_LOW;
            st_nxt.ss_frame = 1'b0;
          end
          else
          begin
            st_nxt.phase = PH_DATA;
            st_nxt.second_half = 1'b0;
            // Zero runs low then middle, one runs middle then low
            st_nxt.level = st_r.word[0] ? wsf_pkg::LEVEL_MID : wsf_pkg::LEVEL_LOW;
          end
        end
      end
      PH_DATA:
      begin
        if (tif.half_tick)
        begin
          if (!st_r.second_half)
          begin
            // Mid bit edge
            st_nxt.second_half = 1'b1;
            st_nxt.level = st_r.word[st_r.bit_idx] ?
                           wsf_pkg::LEVEL_LOW : wsf_pkg::LEVEL_MID;
          end
          else if (st_r.speed_pending)
          begin
            // Bit finished; drop the rest and go for the pulse
            st_nxt.phase = PH_START;
            st_nxt.level = wsf_pkg::LEVEL_LOW;
            st_nxt.ss_frame = 1'b0;
          end
          else if (st_r.bit_idx == wsf_pkg::LAST_BIT)
          begin
            st_nxt.phase = PH_IDLE;
            st_nxt.level = wsf_pkg::LEVEL_LOW;
          end
          else
          begin
            st_nxt.bit_idx = st_r.bit_idx + 4'h1;
            st_nxt.second_half = 1'b0;
            st_nxt.level = st_r.word[st_r.bit_idx + 4'h1] ?
                           wsf_pkg::LEVEL_MID : wsf_pkg::LEVEL_LOW;
          end
        end
      end
      default:
      begin
        st_nxt.phase = PH_IDLE;
        st_nxt.level = wsf_pkg::LEVEL_LOW;
      end
    endcase

    st_nxt.busy = st_nxt.phase != PH_IDLE;
    st_nxt.ss_out = st_nxt.ss_frame && st_nxt.phase != PH_IDLE;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Power on state: measurement invalid until two extremes
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.phase <= PH_IDLE;
      st_r.after_reset <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign current_level = st_r.level;
  assign direction_reset = st_r.dir_reset;
  assign frame_busy = st_r.busy;
  assign standstill_frame = st_r.ss_out;
endmodule

// ==== test/wsf_checker.sv ====
// Purpose: timing checks on the line current of the frame encoder
// Assumes: single clock, level registered by the design
// Notes: durations come from a run counter, not long repetitions
module wsf_checker #(
  parameter int HALF_BIT_CYCLES = 4,
  parameter int TSTOP_CYCLES = 150
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic speed_increment,
  input wire logic [1:0] current_level,
  input wire logic frame_busy,
  input wire logic standstill_frame
);
  localparam int H = HALF_BIT_CYCLES;
  localparam int GO_MAX = H + 3;
  localparam int CUT_MAX = 5 * H + 3;
  logic [1:0] prev_r;
  logic busy_r;
  logic ss_r;
  logic [31:0] run_r;
  logic [31:0] quiet_r;
  logic edge_r;

  always_ff @(posedge clock)
  begin
    prev_r <= current_level;
    busy_r <= frame_busy;
    ss_r <= standstill_frame;
    run_r <= (!nrst || current_level != prev_r) ? 32'h0 : run_r + 32'h1;
    quiet_r <= (!nrst || speed_increment) ? 32'h0 : quiet_r + 32'h1;
    // First edge of a frame follows idle time of any length
    edge_r <= (!nrst || !frame_busy) ? 1'b0 : (edge_r || current_level != prev_r);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence hi_start;
    current_level == wsf_pkg::LEVEL_HIGH && prev_r == wsf_pkg::LEVEL_LOW;
  endsequence
  sequence hi_end;
    prev_r == wsf_pkg::LEVEL_HIGH && current_level != wsf_pkg::LEVEL_HIGH;
  endsequence

  chk_idle_low:
    assert property (!frame_busy |-> current_level == wsf_pkg::LEVEL_LOW)
    else $error("line not low while idle");
  chk_ss_no_high:
    assert property (standstill_frame |-> current_level != wsf_pkg::LEVEL_HIGH)
    else $error("high level in standstill frame");
  chk_pulse_len:
    assert property (hi_end |-> run_r == 32'(2 * H - 1))
    else $error("speed pulse width wrong");
  chk_low_lead:
    assert property (hi_start |-> run_r >= 32'(H - 1))
    else $error("short low phase before pulse");
  chk_half_grid:
    assert property (frame_busy && busy_r && edge_r && current_level != prev_r
      && current_level != wsf_pkg::LEVEL_HIGH && prev_r != wsf_pkg::LEVEL_HIGH
      |-> (run_r + 32'h1) % 32'(H) == 32'h0)
    else $error("data edge off the half bit grid");
  chk_no_mid_high:
    assert property ((current_level == wsf_pkg::LEVEL_HIGH) != (prev_r == wsf_pkg::LEVEL_HIGH)
      |-> current_level != wsf_pkg::LEVEL_MID && prev_r != wsf_pkg::LEVEL_MID)
    else $error("direct step between middle and high");
  chk_go_idle:
    assert property (speed_increment && !frame_busy && current_level == wsf_pkg::LEVEL_LOW
      |-> ##[1:GO_MAX] current_level != wsf_pkg::LEVEL_LOW)
    else $error("frame did not start after increment");
  chk_inc_pulse:
    assert property (speed_increment |-> ##[1:CUT_MAX] hi_start)
    else $error("speed pulse late after increment");
  chk_ss_quiet:
    assert property (standstill_frame && !ss_r |-> quiet_r >= 32'(TSTOP_CYCLES))
    else $error("standstill frame before timeout");
endmodule

bind wheel_speed_frame_encoder wsf_checker #(
  .HALF_BIT_CYCLES(HALF_BIT_CYCLES),
  .TSTOP_CYCLES(TSTOP_CYCLES)
) chk (
  .clock(clock),
  .nrst(nrst),
  .speed_increment(speed_increment),
  .current_level(current_level),
  .frame_busy(frame_busy),
  .standstill_frame(standstill_frame)
);

// ==== test/ecu_model.sv ====
// Purpose: control unit side, decodes frames from the line current
// Assumes: half bit period known in clock cycles
// Notes: a high level in a bit slot means a cut and a new pulse
module ecu_model #(
  parameter int HALF = 4
) (
  input wire logic clock,
  input wire logic [1:0] current_level,
  output logic [8:0] word,
  output logic [1:0] pulse,
  output int nbits,
  output int frames
);
  logic [1:0] a;
  logic [1:0] b;
  logic [1:0] p;
  logic [8:0] w;
  int n;
  int gap;

  task post();
    word = w;
    nbits = n;
    pulse = p;
    frames++;
  endtask

  initial
  begin
    word = 9'h0;
    pulse = 2'h0;
    nbits = 0;
    frames = 0;
    forever
    begin
      @(negedge clock);
      if (current_level != wsf_pkg::LEVEL_LOW)
      begin
        p = current_level;
        w = 9'h0;
        n = 0;
        gap = 3 * HALF + HALF / 2;
        while (n < 9 && gap > 0)
        begin
          repeat (gap) @(negedge clock);
          a = current_level;
          repeat (HALF) @(negedge clock);
          b = current_level;
          gap = HALF;
          if (b == wsf_pkg::LEVEL_HIGH)
          begin
            // Cut frame: pulse began about half a half bit ago
            post();
            p = b;
            w = 9'h0;
            n = 0;
            gap = 3 * HALF;
          end
          else if (a == b)
            gap = 0;
          else
          begin
            w[n] = (a == wsf_pkg::LEVEL_MID);
            n++;
          end
        end
        post();
        while (current_level != wsf_pkg::LEVEL_LOW) @(negedge clock);
      end
    end
  end
endmodule

// ==== test/wheel_speed_frame_encoder_test.sv ====
// Purpose: self-checking bench for the wheel speed frame encoder
// Assumes: short test counts for bit period and standstill timing
// Notes: expected words are built from the input fields here
module wheel_speed_frame_encoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 4;
  localparam int TSTOP = 150;
  localparam int PER = 300;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic speed_increment = 1'h0;
  logic rotation_dir_in = 1'h0;
  logic direction_valid_in = 1'h0;
  logic [2:0] gap_value_in = 3'h0;
  logic gap_invalid_in = 1'h0;
  logic air_gap_alarm_in = 1'h0;
  logic extreme_found = 1'h0;
  logic [1:0] current_level;
  logic frame_busy;
  logic standstill_frame;
  logic direction_reset;
  logic [8:0] word;
  logic [1:0] pulse;
  int nbits;
  int frames;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int dresets = 0;
  time t0;

  wheel_speed_frame_encoder #(
    .HALF_BIT_CYCLES(H),
    .TSTOP_CYCLES(TSTOP),
    .SS_PERIOD_CYCLES(PER)
  ) uut (
    .clock(clock),
    .nrst(nrst),
    .speed_increment(speed_increment),
    .rotation_dir_in(rotation_dir_in),
    .direction_valid_in(direction_valid_in),
    .gap_value_in(gap_value_in),
    .gap_invalid_in(gap_invalid_in),
    .air_gap_alarm_in(air_gap_alarm_in),
    .extreme_found(extreme_found),
    .current_level(current_level),
    .frame_busy(frame_busy),
    .standstill_frame(standstill_frame),
    .direction_reset(direction_reset)
  );
  ecu_model #(.HALF(H)) ecu (.clock(clock), .current_level(current_level), .word(word),
    .pulse(pulse), .nbits(nbits), .frames(frames));

  always #2 clock = ~clock;

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (direction_reset === 1'h1)
      dresets <= dresets + 1;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [8:0] expw(logic al, logic inv, logic dv, logic dr, logic [2:0] g);
    logic [7:0] d;
    d = {g, dr, dv, 1'h0, inv, al};
    return {^d, d};
  endfunction

  task automatic setin(logic al, logic inv, logic dv, logic dr, logic [2:0] g);
    @(negedge clock);
    {air_gap_alarm_in, gap_invalid_in, direction_valid_in, rotation_dir_in} = {al, inv, dv, dr};
    gap_value_in = g;
  endtask

  task automatic inc();
    @(negedge clock);
    speed_increment = 1'h1;
    @(negedge clock);
    speed_increment = 1'h0;
  endtask

  task automatic extremes();
    repeat (2)
    begin
      @(negedge clock);
      extreme_found = 1'h1;
      @(negedge clock);
      extreme_found = 1'h0;
    end
  endtask

  task automatic frame();
    int n0;
    n0 = frames;
    while (frames == n0) @(negedge clock);
  endtask

  task automatic t_power_on();
    check("idle level", {7'h0, current_level}, 9'h0);
    check("idle busy", {8'h0, frame_busy}, 9'h0);
    setin(1'h1, 1'h0, 1'h1, 1'h1, 3'h5);
    inc();
    frame();
    check("meas invalid", {8'h0, word[1]}, 9'h1);
    check("bit count", 9'(nbits), 9'h9);
    check("pulse level", {7'h0, pulse}, {7'h0, wsf_pkg::LEVEL_HIGH});
    check("speed flags", {7'h0, frame_busy, standstill_frame}, 9'h2);
  endtask

  task automatic t_fields();
    logic [7:0] tab[4] = '{8'h00, 8'hff, 8'h14, 8'h69};
    extremes();
    repeat (2)
    begin
      inc();
      frame();
    end
    foreach (tab[i])
    begin
      setin(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][6:4]);
      inc();
      frame();
      check("data word", word, expw(tab[i][0], tab[i][1], tab[i][2], tab[i][3],
        tab[i][6:4]));
    end
  endtask

  task automatic t_shorten();
    for (int j = 1; j < 8; j++)
    begin
      inc();
      while (current_level !== wsf_pkg::LEVEL_HIGH) @(negedge clock);
      // Land the next increment in the middle of data bit j
      repeat (3 * H + 2 * H * j + H) @(negedge clock);
      inc();
      frame();
      check("cut bit count", 9'(nbits), 9'(j + 1));
      frame();
      check("next bit count", 9'(nbits), 9'h9);
    end
  endtask

  task automatic t_standstill();
    setin(1'h1, 1'h0, 1'h1, 1'h1, 3'h6);
    for (int k = 0; k < 5; k++)
    begin
      frame();
      check("ss word", word, 9'h102);
      check("ss pulse", {7'h0, pulse}, {7'h0, wsf_pkg::LEVEL_MID});
      check("ss flags", {7'h0, frame_busy, standstill_frame}, 9'h3);
      check("dir reset", 9'(dresets), 9'(k == 4));
      if (k > 0)
        check("ss period", {8'h0, ($time - t0) inside {[PER * 16 / 5 : PER * 24 / 5]}},
          9'h1);
      t0 = $time;
    end
  endtask

  task automatic t_wake();
    setin(1'h1, 1'h0, 1'h1, 1'h1, 3'h5);
    while (!(current_level === wsf_pkg::LEVEL_MID && standstill_frame === 1'h1))
      @(negedge clock);
    repeat (3 * H + 2 * H * 3 + H) @(negedge clock);
    inc();
    frame();
    check("wake cut", 9'(nbits), 9'h4);
    repeat (2)
    begin
      frame();
      check("wake pulse", {7'h0, pulse}, {7'h0, wsf_pkg::LEVEL_HIGH});
      check("wake gated", word & 9'h01b, 9'h002);
      inc();
    end
    extremes();
    frame();
    check("third frame", word, expw(1'h1, 1'h0, 1'h1, 1'h1, 3'h5));
  endtask

  initial
  begin
    repeat (4) @(negedge clock);
    nrst = 1'h1;
    t_power_on();
    t_fields();
    t_shorten();
    t_standstill();
    t_wake();
    conclude();
  end
endmodule
